/* File: logic/adcmux_ctrl.sv */
// Purpose: control word decode, input routing and conversion timing
// Assumes: host drives chip select and serial clock; pins are asynchronous
// Notes:   result value comes from the analog side on a parallel input
//
// Functional notes
// - pair select high routes pair two, low pair one; start on select rise
// - gain 0, zero 1, apply 1 ties inputs to pair negative; null conversion
// - gain 1, zero 1 ties inputs to span low; null result stored
// - gain 1, zero 0 applies span inputs; gain result to output register
// - apply flag 0 discards word; nothing changes, no conversion
// - step two gain calibration starts from stored null value
// - step three nulls against pair negative; next is signal conversion
// - cycle code sets cycles: 9, 3, 6, 0 give 10240/20480/81920/102400
// - resolution 12, 13, 14 bits plus sign by conversion length
// - oversampling clock is source divided by 1, 4 or 2; 11 prohibited
// - word layout: 15 apply, 12-9 code, 8,7 dividers, 4,3,2 selects, 1,0 sleep
// - previous result shifts out while next word shifts in
// - link and conversion registers clear at reset (select synchroniser resets high); first transfer returns zero
`timescale 1ns/1ps
`default_nettype none
module adcmux_ctrl
  import adcmux_pkg::*;
(
  // clock and reset
  input  wire logic                CLK_SYS,
  input  wire logic                NRST,
  // serial link pins
  input  wire logic                CS_N,
  input  wire logic                SCLK,
  input  wire logic                SERIAL_IN,
  output logic                     SERIAL_RESULT_OUT,
  // clock source pins
  input  wire logic                EXT_OSCILLATOR_PIN,
  input  wire logic                CLOCK_SOURCE_PIN,
  input  wire logic                RC_OSC_TICK,
  // analog side
  input  wire logic [WORD_W-1:0]   RAW_RESULT,
  output adcmux_route_e            INPUT_ROUTE,
  output logic                     OSC_SLEEP_BIT,
  output logic                     ANALOG_SLEEP_BIT,
  // status
  output logic                     BUSY_N,
  output logic [3:0]               RESULT_BITS,
  output logic [WORD_W-1:0]        NULL_VALUE,
  output logic [WORD_W-1:0]        CAL_VALUE
);
  // three-stage synchronisers for pins
  logic [2:0] cs_s, sck_s, sdi_s, ext_oscillator_pin_s, src_s;
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      cs_s   <= SYNC_INIT;
      sck_s  <= 3'h0;
      sdi_s  <= 3'h0;
      ext_oscillator_pin_s <= 3'h0;
      src_s  <= 3'h0;
    end
    else
    begin
      cs_s   <= {cs_s[1:0], CS_N};
      sck_s  <= {sck_s[1:0], SCLK};
      sdi_s  <= {sdi_s[1:0], SERIAL_IN};
      ext_oscillator_pin_s <= {ext_oscillator_pin_s[1:0], EXT_OSCILLATOR_PIN};
      src_s  <= {src_s[1:0], CLOCK_SOURCE_PIN};
    end
  end

  // filtered levels update once stages two and three agree
  logic cs_f, sck_f, ext_oscillator_pin_f, src_sel;
  logic next_cs_f, next_sck_f, next_ext_oscillator_pin_f, next_src_sel;
  always_comb
  begin
    next_src_sel = (src_s[2] == src_s[1]) ? src_s[1] : src_sel;
    next_cs_f   = (cs_s[2] == cs_s[1]) ? cs_s[1] : cs_f;
    next_sck_f  = (sck_s[2] == sck_s[1]) ? sck_s[1] : sck_f;
    next_ext_oscillator_pin_f = (ext_oscillator_pin_s[2] == ext_oscillator_pin_s[1]) ? ext_oscillator_pin_s[1] : ext_oscillator_pin_f;
  end

  // filtered levels, clock source select included, follow the pins after reset release
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      cs_f    <= 1'b1;
      sck_f   <= 1'b0;
      ext_oscillator_pin_f  <= 1'b0;
      src_sel <= 1'b0;
    end
    else
    begin
      cs_f    <= next_cs_f;
      sck_f   <= next_sck_f;
      ext_oscillator_pin_f  <= next_ext_oscillator_pin_f;
      src_sel <= next_src_sel;
    end
  end

  wire logic cs_rise  = next_cs_f & ~cs_f;
  wire logic sck_rise = next_sck_f & ~sck_f & ~cs_f;
  wire logic sck_fall = ~next_sck_f & sck_f & ~cs_f;
  wire logic ext_oscillator_pin_rise = next_ext_oscillator_pin_f & ~ext_oscillator_pin_f;
  wire logic src_tick = src_sel ? RC_OSC_TICK : ext_oscillator_pin_rise;

  // link shift register and control state
  logic [WORD_W-1:0] shreg, next_shreg;
  logic [WORD_W-1:0] out_reg, next_out_reg;
  logic [WORD_W-1:0] null_reg, next_null_reg;
  logic [WORD_W-1:0] cal_reg, next_cal_reg;
  adcmux_cfg_s       cfg, next_cfg;
  logic              sdo, next_sdo;
  logic              busy, next_busy;
  logic [16:0]       cnt, next_cnt;
  logic              osc_tick;

  adcmux_osc_div u_div (
    .clk      (CLK_SYS),
    .nrst     (NRST),
    .src_tick (src_tick),
    .div_sel  (cfg.div_sel),
    .osc_tick (osc_tick)
  );

  // decode a received word into routing and mode
  function automatic adcmux_cfg_s decode(input logic [WORD_W-1:0] w);
    adcmux_cfg_s c;
    c.cycle_code = w[CONV_HI:CONV_LO];
    c.div_sel    = {w[HALVE_BIT], w[QUARTER_BIT]};
    c.pair_two   = w[PAIR_BIT];
    c.osc_sleep  = w[OSC_SLEEP];
    c.ana_sleep  = w[ANA_SLEEP];
    case ({w[GAIN_BIT], w[ZERO_BIT]})
      2'h1:    begin c.route = w[PAIR_BIT] ? ROUTE_N2 : ROUTE_N1; c.mode = MODE_NULL; end
      2'h3:    begin c.route = ROUTE_SPAN_LO; c.mode = MODE_NULL; end
      2'h2:    begin c.route = ROUTE_SPAN; c.mode = MODE_GAIN; end
      default: begin c.route = w[PAIR_BIT] ? ROUTE_P2 : ROUTE_P1; c.mode = MODE_SIGNAL; end
    endcase
    return c;
  endfunction

  // shifting, word apply and conversion timing
  always_comb
  begin
    next_shreg    = shreg;
    next_sdo      = sdo;
    next_out_reg  = out_reg;
    next_null_reg = null_reg;
    next_cal_reg  = cal_reg;
    next_cfg      = cfg;
    next_busy     = busy;
    next_cnt      = cnt;
    if (sck_fall)
      next_sdo = shreg[WORD_W-1];
    if (sck_rise)
      next_shreg = {shreg[WORD_W-2:0], sdi_s[2]};
    if (busy && osc_tick)
    begin
      next_cnt = cnt + 17'h00001;
      if (next_cnt == cycles_of(cfg.cycle_code))
      begin
        next_busy = 1'b0;
        case (cfg.mode)
          MODE_NULL: next_null_reg = RAW_RESULT;
          MODE_GAIN:
          begin
            next_cal_reg = RAW_RESULT - null_reg;
            next_out_reg = RAW_RESULT;
          end
          default:   next_out_reg = RAW_RESULT - null_reg;
        endcase
      end
    end
    if (cs_rise && shreg[APPLY_BIT])
    begin
      next_cfg  = decode(shreg);
      next_busy = 1'b1;
      next_cnt  = 17'h00000;
    end
    if (!next_cs_f && cs_f)
    begin
      next_shreg = out_reg;
      next_sdo   = out_reg[WORD_W-1];
    end
  end

  // register link and conversion state, all zero at reset
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      shreg    <= '0;
      sdo      <= 1'b0;
      out_reg  <= '0;
      null_reg <= '0;
      cal_reg  <= '0;
      cfg      <= '0;
      busy     <= 1'b0;
      cnt      <= 17'h00000;
    end
    else
    begin
      shreg    <= next_shreg;
      sdo      <= next_sdo;
      out_reg  <= next_out_reg;
      null_reg <= next_null_reg;
      cal_reg  <= next_cal_reg;
      cfg      <= next_cfg;
      busy     <= next_busy;
      cnt      <= next_cnt;
    end
  end

  // registered outputs
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      SERIAL_RESULT_OUT <= 1'b0;
      INPUT_ROUTE       <= ROUTE_P1;
      OSC_SLEEP_BIT     <= 1'b0;
      ANALOG_SLEEP_BIT  <= 1'b0;
      BUSY_N            <= 1'b1;
      RESULT_BITS       <= RES_14;
      NULL_VALUE        <= '0;
      CAL_VALUE         <= '0;
    end
    else
    begin
      SERIAL_RESULT_OUT <= next_sdo;
      INPUT_ROUTE       <= next_cfg.route;
      OSC_SLEEP_BIT     <= next_cfg.osc_sleep;
      ANALOG_SLEEP_BIT  <= next_cfg.ana_sleep;
      BUSY_N            <= ~next_busy;
      RESULT_BITS       <= res_of(next_cfg.cycle_code);
      NULL_VALUE        <= next_null_reg;
      CAL_VALUE         <= next_cal_reg;
    end
  end

  // checks
  apply_gate_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (cs_rise && !shreg[APPLY_BIT]) |=> $stable(cfg))
    else $error("discarded word changed configuration");
  start_conv_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (cs_rise && shreg[APPLY_BIT]) |=> busy && cnt == 17'h00000)
    else $error("applied word did not start conversion");
  pair_route_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (cfg.mode == MODE_SIGNAL) |-> (cfg.route == (cfg.pair_two ? ROUTE_P2 : ROUTE_P1)))
    else $error("signal route mismatch");
  null_route_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (cs_rise && shreg[APPLY_BIT] && shreg[ZERO_BIT] && !shreg[GAIN_BIT])
    |=> cfg.route == (cfg.pair_two ? ROUTE_N2 : ROUTE_N1))
    else $error("null route mismatch");
  span_null_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (cs_rise && shreg[APPLY_BIT] && shreg[ZERO_BIT] && shreg[GAIN_BIT])
    |=> cfg.route == ROUTE_SPAN_LO && cfg.mode == MODE_NULL)
    else $error("span null route mismatch");
  gain_route_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (cs_rise && shreg[APPLY_BIT] && !shreg[ZERO_BIT] && shreg[GAIN_BIT])
    |=> cfg.route == ROUTE_SPAN && cfg.mode == MODE_GAIN)
    else $error("gain route mismatch");
  null_store_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (busy && !next_busy && !cs_rise && cfg.mode == MODE_NULL)
    |=> $stable(out_reg) && null_reg == $past(RAW_RESULT))
    else $error("null result misplaced");
  count_end_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    busy |-> cnt < cycles_of(cfg.cycle_code))
    else $error("conversion count overran");
  res_map_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (cfg.cycle_code == CODE_10K) |-> RESULT_BITS == RES_12)
    else $error("resolution mismatch");
  zero_first_a: assert property (@(posedge CLK_SYS)
    !NRST |=> out_reg == '0 && shreg == '0)
    else $error("registers not cleared");
  cv_gain: cover property (@(posedge CLK_SYS) busy && cfg.mode == MODE_GAIN ##1 !busy);
  cv_null: cover property (@(posedge CLK_SYS) busy && cfg.mode == MODE_NULL ##1 !busy);
  cv_sig:  cover property (@(posedge CLK_SYS) busy && cfg.mode == MODE_SIGNAL ##1 !busy);
endmodule
`default_nettype wire

/* File: logic/adcmux_pkg.sv */
// Purpose: shared constants and types for the converter control block
// Assumes: 16-bit control word, first bit shifted is bit 15
// Notes:   counts are oversampling clock cycles
package adcmux_pkg;
  localparam int          WORD_W       = 16;
  localparam int          APPLY_BIT    = 15;
  localparam int          CONV_HI      = 12;
  localparam int          CONV_LO      = 9;
  localparam int          QUARTER_BIT  = 8;
  localparam int          HALVE_BIT    = 7;
  localparam int          PAIR_BIT     = 4;
  localparam int          GAIN_BIT     = 3;
  localparam int          ZERO_BIT     = 2;
  localparam int          OSC_SLEEP    = 1;
  localparam int          ANA_SLEEP    = 0;
  localparam logic [3:0]  CODE_10K     = 4'h9;
  localparam logic [3:0]  CODE_20K     = 4'h3;
  localparam logic [3:0]  CODE_81K     = 4'h6;
  localparam logic [3:0]  CODE_102K    = 4'h0;
  localparam logic [16:0] CYC_10K      = 17'h02800;
  localparam logic [16:0] CYC_20K      = 17'h05000;
  localparam logic [16:0] CYC_81K      = 17'h14000;
  localparam logic [16:0] CYC_102K     = 17'h19000;
  localparam logic [3:0]  RES_12       = 4'hc;
  localparam logic [3:0]  RES_13       = 4'hd;
  localparam logic [3:0]  RES_14       = 4'he;
  localparam logic [1:0]  DIV_ONE      = 2'h0;
  localparam logic [1:0]  DIV_FOUR     = 2'h1;
  localparam logic [1:0]  DIV_TWO      = 2'h2;
  localparam logic [1:0]  DIV_BAD      = 2'h3;
  localparam logic [2:0]  SYNC_INIT    = 3'h7;

  // converter input routing choices
  typedef enum logic [2:0] {
    ROUTE_P1, ROUTE_P2, ROUTE_N1, ROUTE_N2, ROUTE_SPAN_LO, ROUTE_SPAN
  } adcmux_route_e;

  // conversion purpose
  typedef enum logic [1:0] {
    MODE_SIGNAL, MODE_NULL, MODE_GAIN
  } adcmux_mode_e;

  // decoded configuration
  typedef struct packed {
    logic [3:0]    cycle_code;
    logic [1:0]    div_sel;
    logic          pair_two;
    logic          osc_sleep;
    logic          ana_sleep;
    adcmux_route_e route;
    adcmux_mode_e  mode;
  } adcmux_cfg_s;

  // cycles per conversion for a code
  function automatic logic [16:0] cycles_of(input logic [3:0] code);
    case (code)
      CODE_10K: cycles_of = CYC_10K;
      CODE_20K: cycles_of = CYC_20K;
      CODE_81K: cycles_of = CYC_81K;
      default:  cycles_of = CYC_102K;
    endcase
  endfunction

  // magnitude bits for a code
  function automatic logic [3:0] res_of(input logic [3:0] code);
    case (code)
      CODE_10K: res_of = RES_12;
      CODE_20K: res_of = RES_13;
      default:  res_of = RES_14;
    endcase
  endfunction
endpackage

/* File: logic/adcmux_osc_div.sv */
// Purpose: oversampling tick from the selected clock source
// Assumes: source tick is one CLK_SYS cycle wide
// Notes:   the prohibited divider code produces no ticks
`timescale 1ns/1ps
`default_nettype none
module adcmux_osc_div
  import adcmux_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // source and setting
  input  wire logic       src_tick,
  input  wire logic [1:0] div_sel,
  // divided tick
  output logic            osc_tick
);
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic       next_tick;

  // divide source ticks by 1, 2 or 4
  always_comb
  begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (src_tick)
    begin
      next_cnt = cnt + 2'h1;
      case (div_sel)
        DIV_ONE:  next_tick = 1'b1;
        DIV_TWO:  next_tick = cnt[0];
        DIV_FOUR: next_tick = (cnt == 2'h3);
        default:  next_tick = 1'b0;
      endcase
    end
  end

  // register divider state
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cnt      <= 2'h0;
      osc_tick <= 1'b0;
    end
    else
    begin
      cnt      <= next_cnt;
      osc_tick <= next_tick;
    end
  end

  div_rate_a: assert property (@(posedge clk) disable iff (!nrst)
    (src_tick && div_sel == DIV_BAD) |=> !osc_tick)
    else $error("divider ticked on prohibited code");
endmodule
`default_nettype wire

/* File: tb/adcmux_host_model.sv */
// Purpose: host model shifting control words over the serial link
// Assumes: SCLK idles low and only moves inside a frame
// Notes:   half is the SCLK half period in CLK_SYS cycles
`timescale 1ns/1ps
`default_nettype none
module adcmux_host_model
(
  // clock
  input  wire logic clk,
  // serial link
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo
);
  // idle link at time zero
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  // one frame, msb first; result bit taken on each rise
  task automatic xfer(input logic [15:0] w, input int half, output logic [15:0] r);
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      sdi <= w[i];
      repeat (half) @(posedge clk);
      r[i] = sdo;
      sclk <= 1'b1;
      repeat (half) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (half) @(posedge clk);
    cs_n <= 1'b1;
    sdi  <= ~w[0]; // released line shows no stale bit
  endtask
endmodule
`default_nettype wire

/* File: tb/adcmux_ctrl_tb.sv */
// Purpose: self-checking bench for the converter control block
// Assumes: RC tick every cycle, so one oversampling cycle per clock at divide by one
// Notes:   results are checked in the frame after each conversion
`timescale 1ns/1ps
`default_nettype none
module adcmux_ctrl_tb;
  import adcmux_pkg::*;
  logic          clk_sys, nrst, cs_n, sclk, sdi, sdo, osc_sl, ana_sl, busy_n;
  logic          ext_osc = 1'b0;
  logic          clk_src = 1'b1;
  logic          rc_tick = 1'b1;
  logic [15:0]   raw, rd, r1, r2, r3, r4, r5;
  logic [3:0]    res_bits, code;
  logic [15:0]   null_v, cal_v, dif;
  logic [31:0]   seed;
  logic          p, g, z;
  adcmux_route_e route, er;
  int            error_cnt, n_tests, hp;

  // clock generation
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // external clock pin at even duty, four system cycles a period
  initial
  begin
    forever
    begin
      repeat (2) @(posedge clk_sys);
      ext_osc <= ~ext_osc;
    end
  end

  adcmux_host_model i_adcmux_host_model (.clk(clk_sys), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .sdo(sdo));
  adcmux_ctrl i_adcmux_ctrl (.CLK_SYS(clk_sys), .NRST(nrst), .CS_N(cs_n), .SCLK(sclk),
    .SERIAL_IN(sdi), .SERIAL_RESULT_OUT(sdo), .EXT_OSCILLATOR_PIN(ext_osc),
    .CLOCK_SOURCE_PIN(clk_src), .RC_OSC_TICK(rc_tick), .RAW_RESULT(raw), .INPUT_ROUTE(route),
    .OSC_SLEEP_BIT(osc_sl), .ANALOG_SLEEP_BIT(ana_sl), .BUSY_N(busy_n), .RESULT_BITS(res_bits),
    .NULL_VALUE(null_v), .CAL_VALUE(cal_v));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // control word: code, {quarter, halve}, pair, gain, zero, sleeps
  function automatic logic [15:0] mk(input logic [3:0] c, input logic [1:0] dv, input logic a,
    input logic b, input logic d, input logic [1:0] sl);
    mk = {1'b1, 2'h0, c, dv, 2'h0, a, b, d, sl};
  endfunction

  function automatic adcmux_route_e route_exp(input logic a, input logic b, input logic d);
    route_exp = b ? (d ? ROUTE_SPAN_LO : ROUTE_SPAN) :
                d ? (a ? ROUTE_N2 : ROUTE_N1) : (a ? ROUTE_P2 : ROUTE_P1);
  endfunction

  function automatic logic [3:0] res_exp(input logic [3:0] c);
    res_exp = (c == 4'h9) ? 4'hc : (c == 4'h3) ? 4'hd : 4'he;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one frame, then let the select rise reach the core
  task automatic send(input logic [15:0] w);
    i_adcmux_host_model.xfer(w, hp, rd);
    repeat (8) @(posedge clk_sys);
  endtask

  // wait out a running conversion and check its length
  task automatic conv(input int exp);
    int n;
    n = 0;
    while (busy_n !== 1'b1 && n < exp + 50)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= exp + 50)
    begin
      error_cnt++;
      final_report();
    end
    chk(n + 12 > exp && n <= exp + 2, 1);
  endtask

  // main sequence
  initial
  begin
    nrst <= 1'b0;
    raw  <= 16'h0;
    seed = 32'hb775;
    hp   = 6;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(busy_n, 1);
    chk({res_bits, route}, {RES_14, ROUTE_P1});
    chk({null_v, cal_v}, 32'h0);
    // routing and resolution sweep, words restart each other
    for (int i = 0; i < 12; i++)
    begin
      seed = lfsr(seed);
      code = (i == 3) ? CODE_102K : (i == 5) ? CODE_20K : (i == 6) ? CODE_81K : CODE_10K;
      {g, z, p} = (i < 8) ? i[2:0] : seed[2:0];
      g &= (i != 11);
      hp = 6 + 4 * i[0];
      send(mk(code, 2'h0, p, g, z, seed[4:3]));
      if (i == 0)
        chk(rd, 0);
      er = route_exp(p, g, z);
      chk(route, er);
      chk(res_bits, res_exp(code));
      chk({osc_sl, ana_sl, busy_n}, {seed[4:3], 1'b0});
    end
    send({1'b0, seed[31:17]});
    chk({route, res_bits}, {er, res_exp(code)});
    conv(10240 - (32 * hp + 19));
    // three-step calibration, then signal conversions at three divider settings
    r1 = seed[15:0];
    raw <= r1;
    send(mk(CODE_10K, 2'h0, 1'b0, 1'b1, 1'b1, 2'h0));
    conv(10240);
    chk(null_v, r1);
    r2 = seed[31:16];
    raw <= r2;
    send(mk(CODE_10K, 2'h0, 1'b1, 1'b1, 1'b0, 2'h0));
    chk(rd, 0);
    conv(10240);
    dif = r2 - r1;
    chk(cal_v, dif);
    r3 = ~r1;
    raw <= r3;
    send(mk(CODE_10K, 2'h0, 1'b1, 1'b0, 1'b1, 2'h0));
    chk({rd, route}, {r2, ROUTE_N2});
    conv(10240);
    chk(null_v, r3);
    r4 = r2 ^ 16'h5a5a;
    raw <= r4;
    send(mk(CODE_10K, 2'h0, 1'b1, 1'b0, 1'b0, 2'h0));
    chk(rd, r2);
    conv(10240);
    seed = lfsr(seed);
    r5 = seed[15:0] ^ 16'h0f0f;
    raw <= r5;
    send(mk(CODE_10K, 2'h1, 1'b1, 1'b0, 1'b0, 2'h0)); // halve
    dif = r4 - r3;
    chk(rd, dif);
    conv(20480);
    send({1'b0, 15'h0});
    dif = r5 - r3;
    chk(rd, dif);
    repeat (20) @(posedge clk_sys);
    chk(busy_n, 1);
    send(mk(CODE_10K, 2'h3, 1'b1, 1'b0, 1'b0, 2'h0));
    repeat (11000) @(posedge clk_sys);
    chk(busy_n, 0);
    final_report();
  end
endmodule
`default_nettype wire
